// ### hw/csc_pkg.sv
package csc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_SELECT      = 8'h00;
  localparam logic [7:0] ADDR_CH_COUPLE   = 8'h04;
  localparam logic [7:0] ADDR_CH_SHIFT1   = 8'h08;
  localparam logic [7:0] ADDR_CH_SHIFT2   = 8'h0C;
  localparam logic [7:0] ADDR_CH_DELAY    = 8'h10;
  localparam logic [7:0] ADDR_XI_ROLE     = 8'h14;
  localparam logic [7:0] ADDR_XI_COUPLE   = 8'h18;
  localparam logic [7:0] ADDR_XI_SHIFT    = 8'h1C;
  localparam logic [7:0] ADDR_XI_DELAY    = 8'h20;
  localparam logic [7:0] ADDR_WAVE_LEN    = 8'h24;
  localparam logic [7:0] ADDR_RUN_CONT    = 8'h28;
  localparam logic [7:0] ADDR_STATUS      = 8'h2C;

  // Field widths and limits
  localparam int         SHIFT_W          = 24;
  localparam int         DELAY_W          = 16;
  localparam logic [23:0] CH_SHIFT_MARGIN = 24'h000080;
  localparam logic [2:0] SHIFT_GRAIN_MASK = 3'h7;
  // Skew held in picoseconds, signed
  localparam logic signed [15:0] CH_DELAY_MAX = 16'sh0BB8;
  localparam logic signed [15:0] XI_DELAY_MAX = 16'sh1388;

  // Reset values
  localparam logic [23:0] WAVE_LEN_RST    = 24'h000400;
  localparam logic        RUN_CONT_RST    = 1'h1;

  // Selector and role codes
  localparam logic        SEL_PRIMARY     = 1'h0;
  localparam logic        SEL_SECONDARY   = 1'h1;
  localparam logic        ROLE_MASTER     = 1'h0;
  localparam logic        ROLE_SLAVE      = 1'h1;

  // Responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

endpackage

// ### hw/csc_sync2.sv
`timescale 1ns/1ps

// Two-stage synchroniser for one level from another domain
module csc_sync2
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Level in and out
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_q;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // csc_sync2

// ### hw/csc_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module csc_top
(
  // System clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Waveform start strobe from the primary sequencer
  input  wire logic        I_WAVE_START,
  // Synchronisation link
  input  wire logic        I_LINK_PRESENT,
  input  wire logic        I_LINK_CLK,
  output logic             O_LINK_CLK_OE,
  output logic             O_LINK_CLK_SEL,
  // Applied settings to the channel datapaths
  output logic             O_SEC_CLK_FROM_PRI,
  output logic             O_SEC_PHASE_LOCK,
  output logic [23:0]      O_PRI_SHIFT,
  output logic [23:0]      O_SEC_SHIFT,
  output logic [15:0]      O_SEC_DELAY,
  output logic [23:0]      O_XI_SHIFT,
  output logic [15:0]      O_XI_DELAY,
  output logic             O_PRI_IS_MASTER
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings

  logic                    sel_q;
  logic                    ch_couple_q;
  logic [23:0]             pri_shift_q;
  logic [23:0]             sec_shift_q;
  logic signed [15:0]      ch_delay_q;
  logic                    role_q;
  logic                    xi_couple_q;
  logic [23:0]             xi_shift_q;
  logic signed [15:0]      xi_delay_q;
  logic [23:0]             wave_len_q;
  logic                    run_cont_q;

  logic                    aw_held_q;
  logic                    w_held_q;
  logic [7:0]              awaddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    do_write;
  logic [1:0]              wresp;

  logic                    link_present_s;
  logic                    link_clk_s;
  logic                    link_clk_d1_q;
  logic                    link_edge_q;
  logic                    start_s;
  logic                    start_d1_q;
  logic                    start_edge;

  logic [23:0]             wr_val;
  logic signed [15:0]      wr_delay;
  logic                    run_sync;

  assign wr_val   = wdata_q[23:0];
  assign wr_delay = wdata_q[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  csc_sync2 u_sync_present
  (
    .i_clk   (I_CLK_SYS),
    .i_reset (I_RESET),
    .i_async (I_LINK_PRESENT),
    .o_sync  (link_present_s)
  );

  csc_sync2 u_sync_link_clk
  (
    .i_clk   (I_CLK_SYS),
    .i_reset (I_RESET),
    .i_async (I_LINK_CLK),
    .o_sync  (link_clk_s)
  );

  csc_sync2 u_sync_start
  (
    .i_clk   (I_CLK_SYS),
    .i_reset (I_RESET),
    .i_async (I_WAVE_START),
    .o_sync  (start_s)
  );

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      link_clk_d1_q <= 1'b0;
      link_edge_q   <= 1'b0;
      start_d1_q    <= 1'b0;
    end
    else
    begin
      link_clk_d1_q <= link_clk_s;
      link_edge_q   <= link_clk_s & ~link_clk_d1_q;
      start_d1_q    <= start_s;
    end
  end

  assign start_edge = start_s & ~start_d1_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= I_AWADDR;
      end
      else if (do_write)
        aw_held_q <= 1'b0;
      if (I_WVALID && O_WREADY)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= I_WDATA;
        wstrb_q  <= I_WSTRB;
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  assign do_write = aw_held_q & w_held_q & ~O_BVALID;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= csc_pkg::RESP_OKAY;
    end
    else
    begin
      O_AWREADY <= ~aw_held_q & ~(I_AWVALID & O_AWREADY) & ~O_BVALID;
      O_WREADY  <= ~w_held_q & ~(I_WVALID & O_WREADY) & ~O_BVALID;
      if (do_write)
      begin
        O_BVALID <= 1'b1;
        O_BRESP  <= wresp;
      end
      else if (I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  // Out-of-range values are refused with SLVERR and leave the setting alone
  always_comb
  begin
    wresp = csc_pkg::RESP_OKAY;
    unique case (awaddr_q)
      csc_pkg::ADDR_SELECT, csc_pkg::ADDR_CH_COUPLE, csc_pkg::ADDR_XI_ROLE,
      csc_pkg::ADDR_XI_COUPLE, csc_pkg::ADDR_WAVE_LEN, csc_pkg::ADDR_RUN_CONT,
      csc_pkg::ADDR_STATUS:
        wresp = csc_pkg::RESP_OKAY;
      csc_pkg::ADDR_CH_SHIFT1, csc_pkg::ADDR_CH_SHIFT2:
        if (wr_val > wave_len_q - csc_pkg::CH_SHIFT_MARGIN
            || wave_len_q < csc_pkg::CH_SHIFT_MARGIN)
          wresp = csc_pkg::RESP_SLVERR;
      csc_pkg::ADDR_CH_DELAY:
        if (wr_delay > csc_pkg::CH_DELAY_MAX || wr_delay < -csc_pkg::CH_DELAY_MAX)
          wresp = csc_pkg::RESP_SLVERR;
      csc_pkg::ADDR_XI_SHIFT:
        if (wr_val > wave_len_q)
          wresp = csc_pkg::RESP_SLVERR;
      csc_pkg::ADDR_XI_DELAY:
        if (wr_delay > csc_pkg::XI_DELAY_MAX || wr_delay < -csc_pkg::XI_DELAY_MAX)
          wresp = csc_pkg::RESP_SLVERR;
      default:
        wresp = csc_pkg::RESP_DECERR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      sel_q       <= csc_pkg::SEL_PRIMARY;
      ch_couple_q <= 1'b0;
      pri_shift_q <= 24'h000000;
      sec_shift_q <= 24'h000000;
      ch_delay_q  <= 16'sh0000;
      role_q      <= csc_pkg::ROLE_MASTER;
      xi_couple_q <= 1'b0;
      xi_shift_q  <= 24'h000000;
      xi_delay_q  <= 16'sh0000;
      wave_len_q  <= csc_pkg::WAVE_LEN_RST;
      run_cont_q  <= csc_pkg::RUN_CONT_RST;
    end
    else if (do_write && wresp == csc_pkg::RESP_OKAY && wstrb_q != 4'h0)
    begin
      unique case (awaddr_q)
        csc_pkg::ADDR_SELECT:    sel_q       <= wdata_q[0];
        csc_pkg::ADDR_CH_COUPLE: ch_couple_q <= wdata_q[0];
        csc_pkg::ADDR_CH_SHIFT1:
        begin
          // Per-channel shift lands on the channel the selector names
          if (sel_q == csc_pkg::SEL_PRIMARY)
            pri_shift_q <= wr_val;
          else
            sec_shift_q <= wr_val;
        end
        csc_pkg::ADDR_CH_SHIFT2: sec_shift_q <= wr_val;
        csc_pkg::ADDR_CH_DELAY:  ch_delay_q  <= wr_delay;
        csc_pkg::ADDR_XI_ROLE:   role_q      <= wdata_q[0];
        csc_pkg::ADDR_XI_COUPLE: xi_couple_q <= wdata_q[0];
        csc_pkg::ADDR_XI_SHIFT:  xi_shift_q  <= wr_val;
        csc_pkg::ADDR_XI_DELAY:  xi_delay_q  <= wr_delay;
        csc_pkg::ADDR_WAVE_LEN:  wave_len_q  <= wr_val;
        csc_pkg::ADDR_RUN_CONT:  run_cont_q  <= wdata_q[0];
        default:                 sel_q       <= sel_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h00000000;
      O_RRESP   <= csc_pkg::RESP_OKAY;
    end
    else
    begin
      O_ARREADY <= ~O_RVALID & ~(I_ARVALID & O_ARREADY);
      if (I_ARVALID && O_ARREADY)
      begin
        O_RVALID <= 1'b1;
        O_RRESP  <= csc_pkg::RESP_OKAY;
        unique case (I_ARADDR)
          csc_pkg::ADDR_SELECT:    O_RDATA <= {31'h0, sel_q};
          csc_pkg::ADDR_CH_COUPLE: O_RDATA <= {31'h0, ch_couple_q};
          csc_pkg::ADDR_CH_SHIFT1: O_RDATA <= {8'h00, sel_q ? sec_shift_q : pri_shift_q};
          csc_pkg::ADDR_CH_SHIFT2: O_RDATA <= {8'h00, sec_shift_q};
          csc_pkg::ADDR_CH_DELAY:  O_RDATA <= {{16{ch_delay_q[15]}}, ch_delay_q};
          csc_pkg::ADDR_XI_ROLE:   O_RDATA <= {31'h0, role_q};
          csc_pkg::ADDR_XI_COUPLE: O_RDATA <= {31'h0, xi_couple_q};
          csc_pkg::ADDR_XI_SHIFT:  O_RDATA <= {8'h00, xi_shift_q};
          csc_pkg::ADDR_XI_DELAY:  O_RDATA <= {{16{xi_delay_q[15]}}, xi_delay_q};
          csc_pkg::ADDR_WAVE_LEN:  O_RDATA <= {8'h00, wave_len_q};
          csc_pkg::ADDR_RUN_CONT:  O_RDATA <= {31'h0, run_cont_q};
          csc_pkg::ADDR_STATUS:    O_RDATA <= {29'h0, O_LINK_CLK_OE, link_edge_q,
                                               link_present_s};
          default:
          begin
            O_RDATA <= 32'h00000000;
            O_RRESP <= csc_pkg::RESP_DECERR;
          end
        endcase
      end
      else if (I_RREADY)
        O_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied coupling state

  // Link clock driven only by a coupled master with the cable attached
  logic xi_active;
  assign xi_active = xi_couple_q & link_present_s;
  assign run_sync  = run_cont_q & ch_couple_q;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      O_SEC_CLK_FROM_PRI <= 1'b0;
      O_SEC_PHASE_LOCK   <= 1'b0;
      O_LINK_CLK_OE      <= 1'b1;
      O_LINK_CLK_SEL     <= 1'b0;
      O_PRI_IS_MASTER    <= 1'b1;
    end
    else
    begin
      O_SEC_CLK_FROM_PRI <= ch_couple_q;
      O_SEC_PHASE_LOCK   <= ch_couple_q;
      // Output enable low while driving the reference clock
      O_LINK_CLK_OE      <= ~(xi_active && role_q == csc_pkg::ROLE_MASTER);
      // A coupled slave takes its sample clock from the link
      O_LINK_CLK_SEL     <= xi_active && role_q == csc_pkg::ROLE_SLAVE;
      // Secondary never masters; primary masters unless this box is a coupled slave
      O_PRI_IS_MASTER    <= ~xi_active || role_q == csc_pkg::ROLE_MASTER;
    end
  end

  // New values only at a waveform start so a running period is not disturbed
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      O_PRI_SHIFT <= 24'h000000;
      O_SEC_SHIFT <= 24'h000000;
      O_SEC_DELAY <= 16'h0000;
      O_XI_SHIFT  <= 24'h000000;
      O_XI_DELAY  <= 16'h0000;
    end
    else if (start_edge)
    begin
      // Round down to the eight-clock grain; both offsets go out for the
      // datapath to apply as a mutual difference
      O_PRI_SHIFT <= run_sync ? {pri_shift_q[23:3], 3'h0} : 24'h000000;
      O_SEC_SHIFT <= run_sync ? {sec_shift_q[23:3], 3'h0} : 24'h000000;
      O_SEC_DELAY <= run_sync ? ch_delay_q : 16'h0000;
      O_XI_SHIFT  <= xi_active ? {xi_shift_q[23:3], 3'h0} : 24'h000000;
      O_XI_DELAY  <= xi_active ? xi_delay_q : 16'h0000;
    end
  end

endmodule // csc_top

// ### bench/csc_top_sva.sv
`timescale 1ns/1ps

module csc_top_sva
(
  // Clock and reset
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESET,
  // Bus handshakes
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  // Applied settings and link
  input wire logic        O_SEC_CLK_FROM_PRI,
  input wire logic        O_SEC_PHASE_LOCK,
  input wire logic [23:0] O_PRI_SHIFT,
  input wire logic [23:0] O_SEC_SHIFT,
  input wire logic [23:0] O_XI_SHIFT,
  input wire logic [15:0] O_SEC_DELAY,
  input wire logic [15:0] O_XI_DELAY,
  input wire logic        O_LINK_CLK_OE,
  input wire logic        O_LINK_CLK_SEL,
  input wire logic        O_PRI_IS_MASTER
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);

  sequence s_wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_rd_taken;
    I_ARVALID && O_ARREADY;
  endsequence

  // Both halves held after the taking edge; response raised one edge later
  a_write_answer: assert property (s_wr_taken |-> ##2 O_BVALID)
    else $error("write response missing");
  a_bvalid_clears: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response not released");
  a_rvalid_clears: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read data not released");
  a_bresp_stands: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_taken |=> O_RVALID)
    else $error("read data missing");
  a_rdata_stands: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  a_clk_lock_pair: assert property (O_SEC_CLK_FROM_PRI == O_SEC_PHASE_LOCK)
    else $error("clock feed and phase lock differ");
  a_shift_grain: assert property ((O_PRI_SHIFT[2:0] | O_SEC_SHIFT[2:0] | O_XI_SHIFT[2:0]) == 3'h0)
    else $error("shift not a multiple of eight");
  a_sec_delay_range: assert property ($signed(O_SEC_DELAY) <= csc_pkg::CH_DELAY_MAX
    && $signed(O_SEC_DELAY) >= -csc_pkg::CH_DELAY_MAX) else $error("channel delay out of range");
  a_xi_delay_range: assert property ($signed(O_XI_DELAY) <= csc_pkg::XI_DELAY_MAX
    && $signed(O_XI_DELAY) >= -csc_pkg::XI_DELAY_MAX) else $error("link delay out of range");
  // Only a master may drive the shared reference clock
  a_master_drives: assert property (!O_LINK_CLK_OE |-> O_PRI_IS_MASTER && !O_LINK_CLK_SEL)
    else $error("clock driven while not master");
  a_slave_follows: assert property (O_LINK_CLK_SEL |-> !O_PRI_IS_MASTER)
    else $error("slave still claims master");
endmodule // csc_top_sva

bind csc_top csc_top_sva chk_u (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_SEC_CLK_FROM_PRI(O_SEC_CLK_FROM_PRI), .O_SEC_PHASE_LOCK(O_SEC_PHASE_LOCK),
  .O_PRI_SHIFT(O_PRI_SHIFT), .O_SEC_SHIFT(O_SEC_SHIFT), .O_XI_SHIFT(O_XI_SHIFT),
  .O_SEC_DELAY(O_SEC_DELAY), .O_XI_DELAY(O_XI_DELAY), .O_LINK_CLK_OE(O_LINK_CLK_OE),
  .O_LINK_CLK_SEL(O_LINK_CLK_SEL), .O_PRI_IS_MASTER(O_PRI_IS_MASTER));

// ### bench/csc_peer.sv
`timescale 1ns/1ps

module csc_peer
(
  // Bench control
  input  wire logic i_cable,
  input  wire logic i_drive_clk,
  // Link pins
  output logic      o_present,
  output logic      o_link_clk
);
  assign o_present = i_cable;

  // Odd start offset keeps link edges clear of the system clock edges
  initial
  begin
    o_link_clk = 1'b0;
    #37;
    forever
    begin
      #200;
      o_link_clk = i_drive_clk ? ~o_link_clk : 1'b0;
    end
  end
endmodule // csc_peer

// ### bench/tb.sv
`timescale 1ns/1ps

module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ws = 0, cable = 0, peer_clk = 0;
  logic        awready, wready, bvalid, arready, rvalid, present, lclk;
  logic        oe, sel, clk_pri, lock, master;
  logic [1:0]  bresp, rresp;
  logic [23:0] pri_sh, sec_sh, xi_sh;
  logic [15:0] sec_dl, xi_dl;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;

  always #25 clk = ~clk;

  csc_top dut_u (.I_CLK_SYS(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready), .I_WAVE_START(ws), .I_LINK_PRESENT(present),
    .I_LINK_CLK(lclk), .O_LINK_CLK_OE(oe), .O_LINK_CLK_SEL(sel), .O_SEC_CLK_FROM_PRI(clk_pri),
    .O_SEC_PHASE_LOCK(lock), .O_PRI_SHIFT(pri_sh), .O_SEC_SHIFT(sec_sh), .O_SEC_DELAY(sec_dl),
    .O_XI_SHIFT(xi_sh), .O_XI_DELAY(xi_dl), .O_PRI_IS_MASTER(master));

  csc_peer peer_u (.i_cable(cable), .i_drive_clk(peer_clk), .o_present(present),
    .o_link_clk(lclk));

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Response ready offered with the request and held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    // Idle edge so the next call never re-raises a strobe in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
  endtask

  task automatic wave_start();
    ws <= 1'b1;
    repeat (6) @(posedge clk);
    ws <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(csc_pkg::ADDR_SELECT, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_CH_COUPLE, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_CH_SHIFT1, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_CH_DELAY, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_XI_ROLE, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_XI_COUPLE, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_XI_SHIFT, 32'h0, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_XI_DELAY, 32'h0, csc_pkg::RESP_OKAY);
    rd(8'h40, 32'h0, csc_pkg::RESP_DECERR);
    wr(8'h40, 32'h1, csc_pkg::RESP_DECERR);
    rd(csc_pkg::ADDR_SELECT, 32'h0, csc_pkg::RESP_OKAY);
    $display("Test defaults done");
    // One length register serves both channels
    rd(csc_pkg::ADDR_WAVE_LEN, 32'h400, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_CH_COUPLE, 32'h1, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_CH_COUPLE, 32'h1, csc_pkg::RESP_OKAY);
    chk({31'h0, clk_pri & lock}, 32'h1);
    wr(csc_pkg::ADDR_CH_SHIFT1, 32'h13, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_CH_SHIFT1, 32'h13, csc_pkg::RESP_OKAY);
    chk({8'h0, pri_sh}, 32'h0);
    wave_start();
    chk({8'h0, pri_sh}, 32'h10);
    wr(csc_pkg::ADDR_SELECT, 32'h1, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_CH_SHIFT1, 32'h381, csc_pkg::RESP_SLVERR);
    wr(csc_pkg::ADDR_CH_SHIFT1, 32'h380, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_CH_SHIFT2, 32'h380, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_SELECT, 32'h0, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_CH_DELAY, 32'hBB8, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_CH_DELAY, 32'hBB9, csc_pkg::RESP_SLVERR);
    wave_start();
    chk({8'h0, sec_sh}, 32'h380);
    chk({16'h0, sec_dl}, 32'hBB8);
    wr(csc_pkg::ADDR_RUN_CONT, 32'h0, csc_pkg::RESP_OKAY);
    wave_start();
    chk({8'h0, pri_sh}, 32'h0);
    wr(csc_pkg::ADDR_RUN_CONT, 32'h1, csc_pkg::RESP_OKAY);
    $display("Test channel coupling done");
    wr(csc_pkg::ADDR_XI_ROLE, 32'h0, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_XI_COUPLE, 32'h1, csc_pkg::RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({31'h0, oe}, 32'h1);
    cable <= 1'b1;
    repeat (4) @(posedge clk);
    chk({30'h0, oe, master}, 32'h1);
    wr(csc_pkg::ADDR_XI_SHIFT, 32'h401, csc_pkg::RESP_SLVERR);
    wr(csc_pkg::ADDR_XI_SHIFT, 32'h3FC, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_XI_DELAY, 32'h1389, csc_pkg::RESP_SLVERR);
    wr(csc_pkg::ADDR_XI_DELAY, 32'h1388, csc_pkg::RESP_OKAY);
    wave_start();
    chk({8'h0, xi_sh}, 32'h3F8);
    chk({16'h0, xi_dl}, 32'h1388);
    $display("Test master link done");
    wr(csc_pkg::ADDR_XI_COUPLE, 32'h0, csc_pkg::RESP_OKAY);
    wr(csc_pkg::ADDR_XI_ROLE, 32'h1, csc_pkg::RESP_OKAY);
    rd(csc_pkg::ADDR_XI_ROLE, 32'h1, csc_pkg::RESP_OKAY);
    peer_clk <= 1'b1;
    wr(csc_pkg::ADDR_XI_COUPLE, 32'h1, csc_pkg::RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({29'h0, oe, sel, master}, 32'h6);
    $display("Test slave link done");
    final_report();
  end
endmodule // tb
